// ### verilog/shreg_pkg.sv
// Purpose: Shared constants and types for the octal universal shift register
// Assumes: 25 MHz system clock; all device pins arrive asynchronously
// Notes: Register offsets are byte addresses on the Avalon-MM slave

package shreg_pkg;

	// ************************************************************
	// Widths and depths
	// ************************************************************
	localparam int REG_WIDTH = 8;
	localparam int FIFO_DEPTH = 32;
	localparam int BUS_AW = 4;
	localparam int BUS_DW = 32;

	// ************************************************************
	// Register map
	// ************************************************************
	localparam logic [3:0] OFS_CTRL = 4'h0;
	localparam logic [3:0] OFS_STATUS = 4'h4;
	localparam logic [3:0] OFS_DATA = 4'h8;
	localparam int CTRL_CAPTURE_BIT = 0;
	localparam int CTRL_OVF_CLEAR_BIT = 1;
	localparam int STAT_EMPTY_BIT = 8;
	localparam int STAT_FULL_BIT = 9;
	localparam int STAT_OVF_BIT = 10;
	localparam int DATA_VALID_BIT = 8;

	// ************************************************************
	// Reset values
	// ************************************************************
	localparam logic [7:0] STORAGE_RESET = 8'h00;
	localparam logic CAPTURE_RESET = 1'b0;
	localparam logic [31:0] READ_ZERO = 32'h0000_0000;

	// One sample of every device pin, taken through the synchroniser
	typedef struct packed {
		logic clk_pin;
		logic clear_n;
		logic sel_high;
		logic sel_low;
		logic right_in;
		logic left_in;
		logic oe_a_n;
		logic oe_b_n;
		logic [7:0] par;
	} pin_sample_t;

	// Operating modes, one-hot
	typedef enum logic [3:0] {
		MODE_HOLD = 4'b0001,
		MODE_RIGHT = 4'b0010,
		MODE_LEFT = 4'b0100,
		MODE_LOAD = 4'b1000
	} mode_t;

	// Bus slave states, one-hot
	typedef enum logic [1:0] {
		BUS_IDLE = 2'b01,
		BUS_ANSWER = 2'b10
	} bus_state_t;

	// Select pins to operating mode
	function automatic mode_t decode_mode(input logic hi, input logic lo);
		case ({hi, lo})
			2'b11: decode_mode = MODE_LOAD;
			2'b01: decode_mode = MODE_RIGHT;
			2'b10: decode_mode = MODE_LEFT;
			default: decode_mode = MODE_HOLD;
		endcase
	endfunction

endpackage

// ### verilog/word_fifo.sv
// Purpose: Synchronous FIFO with valid/ready on both sides
// Assumes: Single clock; DEPTH is a power of two
// Notes: Output data is the head word, valid while not empty

`timescale 1ns/100ps

module word_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 32
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic ce,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);

	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr_r;
	logic [AW-1:0] rd_ptr_r;
	logic [AW:0] count_r;
	logic push;
	logic pop;

	// ************************************************************
	// Handshake
	// ************************************************************
	assign in_ready = (count_r != DEPTH[AW:0]);
	assign out_valid = (count_r != '0);
	assign out_data = mem[rd_ptr_r];
	assign push = ce & in_valid & in_ready;
	assign pop = ce & out_ready & out_valid;

	// Storage array; no reset so it maps onto RAM
	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_ptr_r] <= in_data;
		end
	end

	// Pointers and occupancy
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			count_r <= '0;
		end else begin
			if (push) begin
				wr_ptr_r <= wr_ptr_r + 1'b1;
			end
			if (pop) begin
				rd_ptr_r <= rd_ptr_r + 1'b1;
			end
			case ({push, pop})
				2'b10: count_r <= count_r + 1'b1;
				2'b01: count_r <= count_r - 1'b1;
				default: count_r <= count_r;
			endcase
		end
	end

endmodule // word_fifo

// ### verilog/octal_universal_shift_register.sv
// Purpose: Eight-bit universal shift/storage register behind its pins
// Assumes: Pins are asynchronous to clk and sampled through two flops
// Notes: Avalon-MM slave exposes storage, FIFO of captured words, control
//
// Implementation choices: the address map and the Avalon-MM slave port.

`timescale 1ns/100ps

module octal_universal_shift_register (
	input wire logic clk,
	input wire logic reset,
	input wire logic ce,
	input wire logic clock_in,
	input wire logic right_shift_serial_in,
	input wire logic left_shift_serial_in,
	input wire logic mode_select_low,
	input wire logic mode_select_high,
	input wire logic sync_clear_n,
	input wire logic output_enable_a_n,
	input wire logic output_enable_b_n,
	input wire logic [7:0] shared_parallel_pins_in,
	output logic [7:0] shared_parallel_pins_out,
	output logic shared_parallel_pins_oe,
	output logic low_end_serial_out,
	output logic high_end_serial_out,
	output logic capture_ready,
	input wire logic [3:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	output logic [31:0] readdata,
	output logic waitrequest
);

	// ************************************************************
	// Declarations
	// ************************************************************
	shreg_pkg::pin_sample_t pin_now;
	shreg_pkg::pin_sample_t smp1_r;
	shreg_pkg::pin_sample_t smp2_r;
	logic clk_prev_r;
	logic edge_ev;
	shreg_pkg::mode_t mode;
	logic [7:0] storage_r;
	logic [7:0] storage_nxt;
	logic [7:0] right_val;
	logic [7:0] left_val;
	logic oe_r;
	logic capture_en_r;
	logic overflow_r;
	logic ready_r;
	logic push_req;
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic [7:0] fifo_out_data;
	logic pop_req;
	logic ovf_clear;
	logic bus_req;
	shreg_pkg::bus_state_t bus_state_r;
	logic [31:0] readdata_r;
	logic waitrequest_r;

	// ************************************************************
	// Pin synchroniser
	// ************************************************************

	// Gather all pins so they cross with the same latency
	always_comb begin
		pin_now.clk_pin = clock_in;
		pin_now.clear_n = sync_clear_n;
		pin_now.sel_high = mode_select_high;
		pin_now.sel_low = mode_select_low;
		pin_now.right_in = right_shift_serial_in;
		pin_now.left_in = left_shift_serial_in;
		pin_now.oe_a_n = output_enable_a_n;
		pin_now.oe_b_n = output_enable_b_n;
		pin_now.par = shared_parallel_pins_in;
	end

	// Two flops; only the second is read by logic. Reset to the idle pin levels
	// (clear and enables inactive) so the drivers stay off until real pins arrive
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			smp1_r <= '{clear_n: 1'b1, oe_a_n: 1'b1, oe_b_n: 1'b1, default: '0};
			smp2_r <= '{clear_n: 1'b1, oe_a_n: 1'b1, oe_b_n: 1'b1, default: '0};
		end else if (ce) begin
			smp1_r <= pin_now;
			smp2_r <= smp1_r;
		end
	end

	// Previous clock pin level for rising-edge detection
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			clk_prev_r <= 1'b0;
		end else if (ce) begin
			clk_prev_r <= smp2_r.clk_pin;
		end
	end

	// Data and selects were sampled together with the clock pin, so the
	// values seen at the detected edge are the ones set up before it
	assign edge_ev = ce & smp2_r.clk_pin & ~clk_prev_r;

	// ************************************************************
	// Storage register
	// ************************************************************

	assign mode = shreg_pkg::decode_mode(smp2_r.sel_high, smp2_r.sel_low);
	assign right_val = {storage_r[6:0], smp2_r.right_in};
	assign left_val = {smp2_r.left_in, storage_r[7:1]};

	// Next value at a clock-pin edge; clear overrides every mode
	always_comb begin
		if (!smp2_r.clear_n) begin
			storage_nxt = shreg_pkg::STORAGE_RESET;
		end else begin
			case (mode)
				shreg_pkg::MODE_LOAD: storage_nxt = smp2_r.par;
				shreg_pkg::MODE_RIGHT: storage_nxt = right_val;
				shreg_pkg::MODE_LEFT: storage_nxt = left_val;
				shreg_pkg::MODE_HOLD: storage_nxt = storage_r;
				default: storage_nxt = storage_r;
			endcase
		end
	end

	// Eight storage bits; output enables play no part here
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			storage_r <= shreg_pkg::STORAGE_RESET;
		end else if (edge_ev) begin
			storage_r <= storage_nxt;
		end
	end

	// ************************************************************
	// Pin drivers
	// ************************************************************

	// Driver enable; load mode releases the pins so the far side can drive
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			oe_r <= 1'b0;
		end else if (ce) begin
			oe_r <= ~smp2_r.oe_a_n & ~smp2_r.oe_b_n
				& (mode != shreg_pkg::MODE_LOAD);
		end
	end

	// All pin outputs are flops directly
	assign shared_parallel_pins_out = storage_r;
	assign shared_parallel_pins_oe = oe_r;
	assign low_end_serial_out = storage_r[0];
	assign high_end_serial_out = storage_r[7];

	// ************************************************************
	// Capture FIFO
	// ************************************************************

	// Each clock-pin edge offers the new storage value when enabled
	assign push_req = edge_ev & capture_en_r;

	word_fifo #(
		.WIDTH(shreg_pkg::REG_WIDTH),
		.DEPTH(shreg_pkg::FIFO_DEPTH)
	) u_fifo (
		.clk(clk),
		.reset(reset),
		.ce(ce),
		.in_valid(push_req),
		.in_ready(fifo_in_ready),
		.in_data(storage_nxt),
		.out_valid(fifo_out_valid),
		.out_ready(pop_req),
		.out_data(fifo_out_data)
	);

	// Ready is registered to keep the output a flop; one cycle stale
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			ready_r <= 1'b1;
		end else if (ce) begin
			ready_r <= fifo_in_ready;
		end
	end

	assign capture_ready = ready_r;

	// Sticky overflow; the register cannot stall, so a lost word is flagged
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			overflow_r <= 1'b0;
		end else if (ce) begin
			if (push_req && !fifo_in_ready) begin
				overflow_r <= 1'b1;
			end else if (ovf_clear) begin
				overflow_r <= 1'b0;
			end
		end
	end

	// ************************************************************
	// Avalon-MM slave
	// ************************************************************

	// A request is accepted in idle; the answer follows one cycle later
	assign bus_req = (read | write) & (bus_state_r == shreg_pkg::BUS_IDLE);
	assign pop_req = bus_req & read & (address == shreg_pkg::OFS_DATA);
	assign ovf_clear = bus_req & write & (address == shreg_pkg::OFS_CTRL)
		& writedata[shreg_pkg::CTRL_OVF_CLEAR_BIT];

	// Handshake sequencing
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			bus_state_r <= shreg_pkg::BUS_IDLE;
			waitrequest_r <= 1'b1;
		end else if (ce) begin
			case (bus_state_r)
				shreg_pkg::BUS_IDLE: begin
					if (read || write) begin
						bus_state_r <= shreg_pkg::BUS_ANSWER;
						waitrequest_r <= 1'b0;
					end
				end
				shreg_pkg::BUS_ANSWER: begin
					bus_state_r <= shreg_pkg::BUS_IDLE;
					waitrequest_r <= 1'b1;
				end
				default: begin
					bus_state_r <= shreg_pkg::BUS_IDLE;
					waitrequest_r <= 1'b1;
				end
			endcase
		end
	end

	// Control register writes
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			capture_en_r <= shreg_pkg::CAPTURE_RESET;
		end else if (ce && bus_req && write && address == shreg_pkg::OFS_CTRL) begin
			capture_en_r <= writedata[shreg_pkg::CTRL_CAPTURE_BIT];
		end
	end

	// Read data; unmapped addresses and empty FIFO read as zero
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			readdata_r <= shreg_pkg::READ_ZERO;
		end else if (ce && bus_req) begin
			readdata_r <= shreg_pkg::READ_ZERO;
			if (read) begin
				case (address)
					shreg_pkg::OFS_CTRL:
						readdata_r[shreg_pkg::CTRL_CAPTURE_BIT] <= capture_en_r;
					shreg_pkg::OFS_STATUS: begin
						readdata_r[7:0] <= storage_r;
						readdata_r[shreg_pkg::STAT_EMPTY_BIT] <= ~fifo_out_valid;
						readdata_r[shreg_pkg::STAT_FULL_BIT] <= ~fifo_in_ready;
						readdata_r[shreg_pkg::STAT_OVF_BIT] <= overflow_r;
					end
					shreg_pkg::OFS_DATA: begin
						readdata_r[7:0] <= fifo_out_valid ? fifo_out_data : 8'h00;
						readdata_r[shreg_pkg::DATA_VALID_BIT] <= fifo_out_valid;
					end
					default: readdata_r <= shreg_pkg::READ_ZERO;
				endcase
			end
		end
	end

	assign readdata = readdata_r;
	assign waitrequest = waitrequest_r;

	// ************************************************************
	// Checks
	// ************************************************************

	default clocking cb @(posedge clk);
	endclocking

	default disable iff (reset);

	sequence s_edge_clear;
		edge_ev && !smp2_r.clear_n;
	endsequence

	sequence s_edge_mode(shreg_pkg::mode_t m);
		edge_ev && smp2_r.clear_n && mode == m;
	endsequence

	property p_clear;
		s_edge_clear |=> storage_r == shreg_pkg::STORAGE_RESET;
	endproperty
	a_clear: assert property (p_clear) else $error("clear did not zero storage");

	property p_no_edge;
		!edge_ev |=> $stable(storage_r);
	endproperty
	a_no_edge: assert property (p_no_edge) else $error("storage moved without edge");

	property p_load;
		s_edge_mode(shreg_pkg::MODE_LOAD) |=> storage_r == $past(smp2_r.par);
	endproperty
	a_load: assert property (p_load) else $error("parallel load wrong");

	property p_right;
		s_edge_mode(shreg_pkg::MODE_RIGHT) |=> storage_r == $past(right_val);
	endproperty
	a_right: assert property (p_right) else $error("right shift wrong");

	property p_left;
		s_edge_mode(shreg_pkg::MODE_LEFT) |=> storage_r == $past(left_val);
	endproperty
	a_left: assert property (p_left) else $error("left shift wrong");

	property p_hold;
		s_edge_mode(shreg_pkg::MODE_HOLD) |=> $stable(storage_r);
	endproperty
	a_hold: assert property (p_hold) else $error("hold changed storage");

	property p_oe_off;
		ce && (smp2_r.oe_a_n || smp2_r.oe_b_n) |=> !shared_parallel_pins_oe;
	endproperty
	a_oe_off: assert property (p_oe_off) else $error("drivers on while disabled");

	property p_load_release;
		ce && mode == shreg_pkg::MODE_LOAD |=> !shared_parallel_pins_oe;
	endproperty
	a_load_release: assert property (p_load_release) else $error("drivers on in load");

	property p_overflow;
		push_req && !fifo_in_ready |=> overflow_r ##1 (overflow_r || $past(ovf_clear));
	endproperty
	a_overflow: assert property (p_overflow) else $error("overflow not held");

endmodule // octal_universal_shift_register

// ### tb/pin_partner.sv
// Purpose: Surrounding logic that works the register's pins
// Assumes: Device pins are sampled on clk, so every pin moves on a clk edge
// Notes: No pull on the shared pins; a released pin drifts every cycle

`timescale 1ns/100ps

module pin_partner (
	input wire logic clk,
	input wire logic [7:0] dev_out,
	input wire logic dev_oe,
	output logic clock_in,
	output logic right_in,
	output logic left_in,
	output logic sel_low,
	output logic sel_high,
	output logic clear_n,
	output logic [7:0] pins
);
	logic drive_r;
	logic [7:0] load_r;
	logic [7:0] last_r;

	// ********************************************************
	// Pin levels
	// ********************************************************
	initial begin
		{clock_in, right_in, left_in, sel_low, sel_high} = 5'h00;
		clear_n = 1'b1;
		drive_r = 1'b0;
		load_r = 8'h00;
		last_r = 8'h00;
	end

	// Wire level: device, then our loader, else a value that never settles
	assign pins = dev_oe ? dev_out : (drive_r ? load_r : ~last_r);

	// Last wire level, so a floating pin never repeats it
	always @(posedge clk) begin
		last_r <= pins;
	end

	// ********************************************************
	// One device clock with its inputs held around it
	// ********************************************************
	task automatic step(input logic [1:0] sel, input logic clr, input logic rin,
		input logic lin, input logic [7:0] d, input logic pulse);
		@(posedge clk);
		sel_high <= sel[1];
		sel_low <= sel[0];
		clear_n <= clr;
		right_in <= rin;
		left_in <= lin;
		// Wait out the device's driver turn-off before loading
		repeat (4) @(posedge clk);
		if (sel == 2'b11) begin
			drive_r <= 1'b1;
			load_r <= d;
		end
		repeat (2) @(posedge clk);
		clock_in <= pulse;
		repeat (3) @(posedge clk);
		clock_in <= 1'b0;
		repeat (3) @(posedge clk);
		drive_r <= 1'b0;
	endtask
endmodule // pin_partner

// ### tb/test_octal_universal_shift_register.sv
// Purpose: Self-checking bench for the octal universal shift register
// Assumes: ce held high except for one frozen stretch in t_enables; pins worked by pin_partner, output enables by this bench
// Notes: Storage model and FIFO queue kept here, compared at pins and bus

`timescale 1ns/100ps

module test_octal_universal_shift_register;
	logic clk, reset, oe_a_n, oe_b_n, read, write, waitrequest, dev_oe;
	logic clock_in, rin, lin, sel_lo, sel_hi, clr_n, low_out, high_out, cap_rdy;
	logic [3:0] address;
	logic [31:0] writedata, readdata, rd;
	logic [7:0] pins, dev_out, expv;
	logic [7:0] fq[$];
	logic cap, ovf, ce;
	int errors, compares;

	octal_universal_shift_register uut (.clk(clk), .reset(reset), .ce(ce),
		.clock_in(clock_in), .right_shift_serial_in(rin), .left_shift_serial_in(lin),
		.mode_select_low(sel_lo), .mode_select_high(sel_hi), .sync_clear_n(clr_n),
		.output_enable_a_n(oe_a_n), .output_enable_b_n(oe_b_n),
		.shared_parallel_pins_in(pins), .shared_parallel_pins_out(dev_out),
		.shared_parallel_pins_oe(dev_oe), .low_end_serial_out(low_out),
		.high_end_serial_out(high_out), .capture_ready(cap_rdy), .address(address),
		.read(read), .write(write), .writedata(writedata), .readdata(readdata),
		.waitrequest(waitrequest));

	pin_partner far (.clk(clk), .dev_out(dev_out), .dev_oe(dev_oe), .clock_in(clock_in),
		.right_in(rin), .left_in(lin), .sel_low(sel_lo), .sel_high(sel_hi),
		.clear_n(clr_n), .pins(pins));

	// ********************************************************
	// Shared tasks
	// ********************************************************
	task automatic end_of_test();
		$display("errors %0d compares %0d", errors, compares);
		if (errors == 0 && compares > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			errors++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// One Avalon cycle; an edge passes first so strobes never change twice at once
	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd);
		int n;
		@(posedge clk);
		address <= a;
		writedata <= wd;
		read <= !wr;
		write <= wr;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (waitrequest !== 1'b0 && n < 50);
		rd = readdata;
		read <= 1'b0;
		write <= 1'b0;
		if (waitrequest !== 1'b0) begin
			errors++;
			end_of_test();
		end
		if (wr && a == shreg_pkg::OFS_CTRL) begin
			cap = wd[0];
			ovf = ovf && !wd[1];
		end
	endtask

	// One device clock, mirrored in the storage model and FIFO queue
	task automatic op(input logic [1:0] sel, input logic clr, input logic r, input logic l,
		input logic [7:0] d, input logic pulse);
		far.step(sel, clr, r, l, d, pulse);
		if (pulse) begin
			if (!clr) expv = 8'h00;
			else if (sel == 2'b11) expv = d;
			else if (sel == 2'b01) expv = {expv[6:0], r};
			else if (sel == 2'b10) expv = {l, expv[7:1]};
			if (cap && fq.size() == 32) ovf = 1'b1;
			else if (cap) fq.push_back(expv);
		end
	endtask

	// Storage at the pins, the serial ends and through STATUS
	task automatic chk_store();
		check("storage", {24'h0, dev_out}, {24'h0, expv});
		check("serial ends", {30'h0, high_out, low_out}, {30'h0, expv[7], expv[0]});
		bus(1'b0, shreg_pkg::OFS_STATUS, 32'h0);
		check("status", rd, {21'h0, ovf, fq.size() == 32, fq.size() == 0, expv});
	endtask

	// ********************************************************
	// Scenarios
	// ********************************************************
	task automatic t_modes();
		chk_store();
		op(2'b11, 1'b1, 1'b0, 1'b0, 8'ha5, 1'b1);
		check("oe in load", {31'h0, dev_oe}, 32'h0);
		chk_store();
		op(2'b01, 1'b1, 1'b1, 1'b0, 8'h00, 1'b1);
		chk_store();
		op(2'b10, 1'b1, 1'b0, 1'b1, 8'h00, 1'b1);
		op(2'b10, 1'b1, 1'b0, 1'b0, 8'h00, 1'b1);
		chk_store();
		op(2'b00, 1'b1, 1'b1, 1'b1, 8'h3c, 1'b1);
		chk_store();
		op(2'b01, 1'b1, 1'b1, 1'b0, 8'h00, 1'b0);
		chk_store();
		op(2'b11, 1'b0, 1'b1, 1'b1, 8'hff, 1'b1);
		chk_store();
		op(2'b11, 1'b1, 1'b0, 1'b0, 8'h81, 1'b1);
	endtask

	task automatic t_enables();
		op(2'b00, 1'b1, 1'b0, 1'b0, 8'h00, 1'b0);
		oe_a_n <= 1'b1;
		repeat (5) @(posedge clk);
		check("oe a", {31'h0, dev_oe}, 32'h0);
		oe_a_n <= 1'b0;
		oe_b_n <= 1'b1;
		op(2'b01, 1'b1, 1'b0, 1'b0, 8'h00, 1'b1);
		check("oe b", {31'h0, dev_oe}, 32'h0);
		chk_store();
		// Frozen clock enable: a pin clock edge in that time must be ignored
		ce <= 1'b0;
		far.step(2'b01, 1'b1, 1'b1, 1'b0, 8'h00, 1'b1);
		ce <= 1'b1;
		repeat (3) @(posedge clk);
		chk_store();
		oe_b_n <= 1'b0;
		repeat (5) @(posedge clk);
		check("oe on", {31'h0, dev_oe}, 32'h1);
		check("pins", {24'h0, pins}, {24'h0, expv});
	endtask

	// Fill past full, drain past empty, clear overflow, unmapped place
	task automatic t_fifo();
		bus(1'b1, shreg_pkg::OFS_CTRL, 32'h1);
		bus(1'b0, shreg_pkg::OFS_CTRL, 32'h0);
		check("ctrl on", rd, 32'h1);
		for (int i = 0; i < 33; i++) begin
			op(2'b01, 1'b1, i[1], 1'b0, 8'h00, 1'b1);
		end
		check("ready full", {31'h0, cap_rdy}, 32'h0);
		chk_store();
		for (int i = 0; i < 33; i++) begin
			bus(1'b0, shreg_pkg::OFS_DATA, 32'h0);
			check("data", rd, fq.size() ? {23'h0, 1'b1, fq.pop_front()} : 32'h0);
		end
		bus(1'b1, shreg_pkg::OFS_CTRL, 32'h2);
		chk_store();
		bus(1'b1, 4'hc, 32'hff);
		bus(1'b0, 4'hc, 32'h0);
		check("unmapped", rd, 32'h0);
		bus(1'b0, shreg_pkg::OFS_CTRL, 32'h0);
		check("ctrl", rd, 32'h0);
	endtask

	// ********************************************************
	// Clock and main sequence
	// ********************************************************
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	initial begin
		{reset, oe_a_n, oe_b_n, read, write} = 5'h10;
		address = 4'h0;
		writedata = 32'h0;
		{errors, compares} = 0;
		{cap, ovf} = 2'b00;
		ce = 1'b1;
		expv = 8'h00;
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		check("wait idle", {31'h0, waitrequest}, 32'h1);
		check("ready", {31'h0, cap_rdy}, 32'h1);
		t_modes();
		t_enables();
		t_fifo();
		end_of_test();
	end
endmodule // test_octal_universal_shift_register
